// ---- lsc_link_ctrl.sv ----
/*
  Link sync and lane control: Wishbone register slave, sync request
  selection, sample FIFO, coding, scrambler and lane mapping.
  Assumes a classic Wishbone master and a lane serializer that takes
  one word per cycle while lane_ready_i is high.
*/
`timescale 1ns/100ps
`default_nettype none
module lsc_link_ctrl
  import lsc_pkg::*;
#(
  parameter int DW = 9,
  parameter int NLANE = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic single_ended_sync_pin_n_i,
  input wire logic timestamp_pin_pair_n_i,
  output logic timestamp_receiver_enable_o,
  output logic sync_request_o,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic [DW-1:0] sample_i,
  input wire logic lane_ready_i,
  output logic [NLANE*DW-1:0] lane_data_o,
  output logic [NLANE-1:0] lane_strobe_o,
  output logic [NLANE-1:0] lane_active_o,
  output logic serializer_power_down_o,
  output logic clock_run_o,
  output logic mfc_reset_o
);
  generate
    if (NLANE != 8 || DW < 2) begin : g_bad
      $error("Lane mapping needs eight lanes and DW of at least 2");
    end
  endgenerate

  // Register storage, defined bits only
  logic soft_sync_request_n;
  logic scrambler_enable;
  logic sample_coding;
  lsc_src_t sync_src;
  logic upper_lane_mapping;
  logic link_subsystem_enable;
  logic timestamp_receiver_enable;
  logic enc_64b66b;
  logic [2:0] lane_count_m1;

  // Bus decode
  wire [9:0] wb_idx = wb_adr_i[11:2];
  wire wb_req = wb_cyc_i && wb_stb_i;
  wire wb_wr = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire hit_soft = (wb_idx == IDX_SOFT_SYNC);
  wire hit_ctrl = (wb_idx == IDX_LINK_CTRL);
  wire hit_setup = (wb_idx == IDX_LINK_SETUP);
  wire hit_status = (wb_idx == IDX_STATUS);
  wire hit_any = hit_soft || hit_ctrl || hit_setup || hit_status;

  wire [7:0] rd_soft = {7'h00, soft_sync_request_n};
  wire [7:0] rd_ctrl = {3'h0, upper_lane_mapping, sync_src,
                        sample_coding, scrambler_enable};
  wire [7:0] rd_setup = {1'b0, lane_count_m1, 1'b0, enc_64b66b,
                         timestamp_receiver_enable, link_subsystem_enable};
  logic fifo_out_valid;
  logic fifo_in_ready;
  wire [7:0] rd_status = {5'h00, ~fifo_in_ready, ~fifo_out_valid,
                          sync_request_o};
  wire [7:0] rd_mux = hit_soft ? rd_soft :
                      hit_ctrl ? rd_ctrl :
                      hit_setup ? rd_setup :
                      hit_status ? rd_status : 8'h00;

  // One wait state, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_mux};
    end
  end

  // Reserved bits are not stored and read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_sync_request_n <= RST_SOFT_SYNC[0]; // see (RULE15)
    end else if (wb_wr && hit_soft) begin
      soft_sync_request_n <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scrambler_enable <= RST_LINK_CTRL[POS_SCRAMBLE]; // see (RULE15)
      sample_coding <= RST_LINK_CTRL[POS_CODING];
      sync_src <= lsc_src_t'(RST_LINK_CTRL[POS_SRC +: 2]);
      upper_lane_mapping <= RST_LINK_CTRL[POS_UPPER];
    end else if (wb_wr && hit_ctrl) begin
      scrambler_enable <= wb_dat_i[POS_SCRAMBLE];
      sample_coding <= wb_dat_i[POS_CODING];
      sync_src <= lsc_src_t'(wb_dat_i[POS_SRC +: 2]);
      upper_lane_mapping <= wb_dat_i[POS_UPPER];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_subsystem_enable <= RST_LINK_SETUP[POS_ENABLE];
      timestamp_receiver_enable <= RST_LINK_SETUP[POS_TS_EN];
      enc_64b66b <= RST_LINK_SETUP[POS_ENC64];
      lane_count_m1 <= RST_LINK_SETUP[POS_LANES +: 3];
    end else if (wb_wr && hit_setup) begin
      link_subsystem_enable <= wb_dat_i[POS_ENABLE];
      timestamp_receiver_enable <= wb_dat_i[POS_TS_EN];
      enc_64b66b <= wb_dat_i[POS_ENC64];
      lane_count_m1 <= wb_dat_i[POS_LANES +: 3];
    end
  end

  // Sync request source selection
  assign timestamp_receiver_enable_o = timestamp_receiver_enable;
  wire se_low = (sync_src == LSC_SRC_SE_PIN) && !single_ended_sync_pin_n_i;
  wire ts_low = (sync_src == LSC_SRC_TS_PIN) && timestamp_receiver_enable
                && !timestamp_pin_pair_n_i; // see (RULE8)
  wire pin_request = se_low || ts_low; // see (RULE7) (RULE3)
  assign sync_request_o = !soft_sync_request_n
                          || pin_request; // see (RULE1) (RULE2) (RULE17)

  // Disabled link held in reset
  wire link_off = !link_subsystem_enable; // see (RULE16)
  assign serializer_power_down_o = link_off;
  assign clock_run_o = link_subsystem_enable;
  assign mfc_reset_o = link_off;

  // Sample FIFO, flushed while the link is off
  logic [DW-1:0] fifo_out;
  wire take = fifo_out_valid && lane_ready_i && !sync_request_o
              && link_subsystem_enable;
  assign sample_ready_o = fifo_in_ready;

  lsc_fifo #(
    .W(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(link_off),
    .in_valid_i(sample_valid_i),
    .in_ready_o(fifo_in_ready),
    .in_data_i(sample_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(take),
    .out_data_o(fifo_out)
  );

  // Offset binary flips the sign bit
  wire [DW-1:0] coded = {fifo_out[DW-1] ^ !sample_coding,
                         fifo_out[DW-2:0]}; // see (RULE9)

  // Self-synchronous scrambler, 1 + x^14 + x^15
  logic [14:0] scramble_state;
  logic [DW-1:0] scrambled_word;
  logic [14:0] next_scramble_state;
  always_comb begin
    next_scramble_state = scramble_state;
    scrambled_word = coded;
    for (int b = DW - 1; b >= 0; b--) begin
      scrambled_word[b] = coded[b] ^ next_scramble_state[14]
                          ^ next_scramble_state[13];
      next_scramble_state = {next_scramble_state[13:0], scrambled_word[b]};
    end
  end
  wire scramble_on = enc_64b66b || scrambler_enable; // see (RULE10) (RULE11)
  wire [DW-1:0] out_word = scramble_on ? scrambled_word : coded;

  always_ff @(posedge clk_i) begin
    if (rst_i || link_off) begin
      scramble_state <= SCRAMBLE_SEED;
    end else if (take && scramble_on) begin
      scramble_state <= next_scramble_state;
    end
  end

  // Lane mapping, round robin over L lanes
  logic [2:0] lane_sel;
  wire [2:0] lane_base = upper_lane_mapping ? UPPER_BASE : 3'h0;
  wire [2:0] phys_lane = lane_sel + lane_base; // see (RULE4) (RULE5)
  wire [2:0] next_lane_sel = (lane_sel == lane_count_m1) ? 3'h0
                             : lane_sel + 3'h1;

  always_ff @(posedge clk_i) begin
    if (rst_i || link_off) begin
      lane_sel <= 3'h0;
    end else if (take) begin
      lane_sel <= next_lane_sel;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NLANE; g++) begin : g_lane
      wire [2:0] lane_no = 3'(g);
      wire [2:0] rel = lane_no - lane_base;
      wire in_range = (upper_lane_mapping ? (lane_no >= UPPER_BASE) : 1'b1)
                      && (rel <= lane_count_m1); // see (RULE4) (RULE5)
      wire hit = take && (phys_lane == lane_no);
      always_ff @(posedge clk_i) begin
        if (rst_i || link_off) begin
          lane_data_o[g*DW +: DW] <= '0;
          lane_strobe_o[g] <= 1'b0;
          lane_active_o[g] <= 1'b0;
        end else begin
          lane_strobe_o[g] <= hit;
          lane_active_o[g] <= in_range;
          if (hit) begin
            lane_data_o[g*DW +: DW] <= out_word;
          end
        end
      end
    end
  endgenerate

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_manual_sync: assert property ( // see (RULE1) (RULE2)
    !soft_sync_request_n |-> sync_request_o && !take)
    else $error("manual sync bit did not raise a request");

  a_pin_hold_low: assert property ( // see (RULE3)
    (sync_src == LSC_SRC_SE_PIN) && !single_ended_sync_pin_n_i
    |-> sync_request_o)
    else $error("low sync pin did not hold the request");

  a_soft_only_src: assert property ( // see (RULE7)
    (sync_src == LSC_SRC_SOFT) && soft_sync_request_n |-> !sync_request_o)
    else $error("software-only source still follows a pin");

  a_ts_source: assert property ( // see (RULE7)
    (sync_src == LSC_SRC_TS_PIN) && timestamp_receiver_enable
    && soft_sync_request_n |-> sync_request_o == !timestamp_pin_pair_n_i)
    else $error("timestamp pair not used as sync source");

  a_lower_lanes: assert property ( // see (RULE4)
    take && !upper_lane_mapping
    |=> lane_strobe_o == (8'h01 << $past(lane_sel)))
    else $error("normal mapping used the wrong lane");

  a_upper_lanes: assert property ( // see (RULE5)
    take && upper_lane_mapping
    |=> lane_strobe_o[3:0] == 4'h0 && lane_strobe_o != 8'h00)
    else $error("upper mapping touched lanes 0 to 3");

  a_coding_plain: assert property ( // see (RULE9) (RULE10)
    take && !scramble_on |=> lane_data_o[$past(phys_lane)*DW +: DW]
    == ($past(fifo_out) ^ {!$past(sample_coding), {(DW-1){1'b0}}}))
    else $error("sample coding or unscrambled word wrong");

  a_scramble_forced: assert property ( // see (RULE11)
    take && enc_64b66b |=> lane_data_o[$past(phys_lane)*DW +: DW]
    == $past(scrambled_word))
    else $error("64b66b payload not scrambled");

  a_disable_hold: assert property ( // see (RULE16)
    link_off |-> serializer_power_down_o && !clock_run_o && mfc_reset_o
    ##1 lane_strobe_o == 8'h00 && !fifo_out_valid)
    else $error("disabled link not held in reset");

  a_reset_values: assert property ( // see (RULE15)
    $past(rst_i) |-> rd_soft == RST_SOFT_SYNC && rd_ctrl == RST_LINK_CTRL)
    else $error("register reset value wrong");

  a_bus_ack: assert property (
    wb_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one cycle after request");

  a_lower_active: assert property ( // see (RULE4)
    link_subsystem_enable && !upper_lane_mapping
    |=> lane_active_o == 8'((9'h002 << $past(lane_count_m1)) - 9'h001))
    else $error("normal mapping lane set wrong");

  a_upper_active: assert property ( // see (RULE5)
    link_subsystem_enable && upper_lane_mapping
    |=> lane_active_o[3:0] == 4'h0 && lane_active_o[4])
    else $error("upper mapping left low lanes active");

  a_src_unused: assert property ( // see (RULE7)
    (sync_src == LSC_SRC_NONE) && soft_sync_request_n |-> !sync_request_o)
    else $error("unused source code raised a request");

  a_ts_gated: assert property ( // see (RULE8)
    (sync_src == LSC_SRC_TS_PIN) && !timestamp_receiver_enable
    && soft_sync_request_n |-> !sync_request_o)
    else $error("disabled timestamp receiver raised a request");

  a_one_lane: assert property ( // see (RULE4) (RULE5)
    take |=> $onehot(lane_strobe_o))
    else $error("word sent on more or fewer than one lane");

  a_lane_bound: assert property ( // see (RULE4)
    take |-> lane_sel <= lane_count_m1)
    else $error("lane index beyond lane count");

  a_sync_stalls: assert property ( // see (RULE1)
    sync_request_o |=> lane_strobe_o == 8'h00)
    else $error("lane word sent during sync request");

  a_unmapped_zero: assert property (
    wb_req && !hit_any |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped index returned data");

  a_status_sync: assert property ( // see (RULE17)
    wb_req && hit_status |=> wb_dat_o[0] == $past(sync_request_o))
    else $error("status does not show the sync request");

  a_write_lands: assert property ( // see (RULE1)
    wb_wr && hit_soft |=> soft_sync_request_n == $past(wb_dat_i[0]))
    else $error("manual sync write not stored");

  a_enabled_run: assert property ( // see (RULE16)
    link_subsystem_enable |-> clock_run_o && !serializer_power_down_o
    && !mfc_reset_o)
    else $error("enabled link still held in reset");

  c_soft_sync: cover property (!soft_sync_request_n ##1 soft_sync_request_n);
  c_upper_take: cover property (take && upper_lane_mapping);
  c_fifo_full: cover property (!fifo_in_ready ##1 take);
  c_mode64_take: cover property (take && enc_64b66b && !scrambler_enable);
  c_ts_request: cover property (ts_low);
endmodule : lsc_link_ctrl
`default_nettype wire

// ---- lsc_pkg.sv ----
/*
  Constants for the link sync and lane control block: register indices,
  field positions and reset values.
  Assumes a classic Wishbone host, byte address equal to four times index.
*/
// Notes on behaviour
// (RULE1) Manual sync bit at 0 requests link sync, like a low receiver sync.
// (RULE2) Manual sync bit requests sync whatever sync source is selected.
// (RULE3) A low selected sync pin holds the request until another source is chosen.
// (RULE4) Lane mapping bit 0 sends on lanes 0 to L-1.
// (RULE5) Lane mapping bit 1 sends on lanes 4 to 4+L-1, lanes 0-3 idle.
// (RULE6) Software picks upper mapping only for modes with four or fewer lanes.
// (RULE7) Source field: 0 single-ended pin, 1 timestamp pair, 2 software only.
// (RULE8) Software enables the timestamp receiver when choosing source 1.
// (RULE9) Sample coding bit: 0 offset binary, 1 two's complement.
// (RULE10) In 8b/10b modes the scrambler bit turns scrambling off or on.
// (RULE11) In 64b/66b modes payload is always scrambled, bit ignored.
// (RULE12) Software should keep the 8b/10b scrambler enabled.
// (RULE13) Software changes link control only while the link is disabled.
// (RULE14) Software writes reserved bits as zero.
// (RULE15) Reset values: manual sync reads 0x01, link control reads 0x03.
// (RULE16) Disabled link: logic in reset, serializers down, clocks off, mfc reset.
// (RULE17) Sync request active on manual bit 0 or selected pin low.
package lsc_pkg;
  localparam logic [9:0] IDX_SOFT_SYNC = 10'h203;
  localparam logic [9:0] IDX_LINK_CTRL = 10'h204;
  localparam logic [9:0] IDX_LINK_SETUP = 10'h210;
  localparam logic [9:0] IDX_STATUS = 10'h211;
  localparam logic [7:0] RST_SOFT_SYNC = 8'h01;
  localparam logic [7:0] RST_LINK_CTRL = 8'h03;
  localparam logic [7:0] RST_LINK_SETUP = 8'h00;
  // Link control fields
  localparam int POS_SCRAMBLE = 0;
  localparam int POS_CODING = 1;
  localparam int POS_SRC = 2;
  localparam int POS_UPPER = 4;
  // Link setup fields
  localparam int POS_ENABLE = 0;
  localparam int POS_TS_EN = 1;
  localparam int POS_ENC64 = 2;
  localparam int POS_LANES = 4;
  // Status fields
  localparam int POS_ST_SYNC = 0;
  localparam int POS_ST_EMPTY = 1;
  localparam int POS_ST_FULL = 2;
  localparam logic [2:0] UPPER_BASE = 3'h4;
  localparam logic [14:0] SCRAMBLE_SEED = 15'h7fff;
  typedef enum logic [1:0] {
    LSC_SRC_SE_PIN,
    LSC_SRC_TS_PIN,
    LSC_SRC_SOFT,
    LSC_SRC_NONE
  } lsc_src_t;
endpackage : lsc_pkg

// ---- lsc_fifo.sv ----
/*
  Sample FIFO with valid/ready on both sides, storage in flip-flops.
  Assumes one clock; flush_i empties it in one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module lsc_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
      $error("DEPTH must be a power of two, at least 2");
    end
  endgenerate
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : lsc_fifo
`default_nettype wire

// ---- lsc_rx_model.sv ----
/*
  Far-side lane receiver model: collects lane words, drives sync pins.
  Assumes the bench's clock and reset and an eight-lane, 9-bit link.
*/
`timescale 1ns/100ps
`default_nettype none
module lsc_rx_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic sync_low_i,
  input wire logic ts_low_i,
  input wire logic [7:0] lane_strobe_i,
  input wire logic [71:0] lane_data_i,
  output logic lane_ready_o,
  output logic sync_n_o,
  output logic ts_n_o
);
  logic [8:0] got_q[$];
  int lane_q[$];
  logic odd;
  // Active-low request levels towards the block
  assign sync_n_o = !sync_low_i;
  assign ts_n_o = !ts_low_i;
  // Slow mode refuses every other cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      odd <= 1'b0;
      lane_ready_o <= 1'b0;
    end else begin
      odd <= !odd;
      lane_ready_o <= !(stall_i && odd);
    end
  end
  // Record each lane word with its lane number
  always @(posedge clk_i) begin
    for (int g = 0; g < 8; g++) begin
      if (lane_strobe_i[g]) begin
        got_q.push_back(lane_data_i[g*9 +: 9]);
        lane_q.push_back(g);
      end
    end
  end
endmodule : lsc_rx_model
`default_nettype wire

// ---- link_sync_lane_control_tb_top.sv ----
/*
  Self-checking bench for the link sync and lane control block.
  Assumes lsc_pkg, lsc_fifo, lsc_link_ctrl and lsc_rx_model compiled.
*/
`timescale 1ns/100ps
`default_nettype none
module link_sync_lane_control_tb_top
  import lsc_pkg::*;
;
  localparam logic [11:0] A_SOFT = {IDX_SOFT_SYNC, 2'b00};
  localparam logic [11:0] A_CTRL = {IDX_LINK_CTRL, 2'b00};
  localparam logic [11:0] A_SETUP = {IDX_LINK_SETUP, 2'b00};
  localparam logic [11:0] A_STAT = {IDX_STATUS, 2'b00};
  localparam logic [11:0] A_NONE = 12'h3fc;
  logic clk_i, rst_i, cyc, stb, we, stall, se_low, ts_low, s_valid;
  logic ack, ts_en, sync_req, s_ready, lready, se_n, ts_n, pdown, crun, mfcr;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [8:0] s_data;
  logic [71:0] lane_data;
  logic [7:0] strobe, active;
  int err_count, n_tests;

  lsc_link_ctrl #(.DW(9), .NLANE(8), .FIFO_DEPTH(16)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .single_ended_sync_pin_n_i(se_n),
    .timestamp_pin_pair_n_i(ts_n), .timestamp_receiver_enable_o(ts_en),
    .sync_request_o(sync_req), .sample_valid_i(s_valid),
    .sample_ready_o(s_ready), .sample_i(s_data), .lane_ready_i(lready),
    .lane_data_o(lane_data), .lane_strobe_o(strobe),
    .lane_active_o(active), .serializer_power_down_o(pdown),
    .clock_run_o(crun), .mfc_reset_o(mfcr));

  lsc_rx_model model (
    .clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .sync_low_i(se_low),
    .ts_low_i(ts_low), .lane_strobe_i(strobe), .lane_data_i(lane_data),
    .lane_ready_o(lready), .sync_n_o(se_n), .ts_n_o(ts_n));

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic give_up(input string what);
    err_count++;
    $display("wrong value at %0t: %s timed out", $time, what);
    end_of_test();
  endtask : give_up

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // One classic cycle; read data left in q
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) give_up("bus");
  endtask : wb

  task automatic push(input logic [8:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    s_valid <= 1'b1;
    s_data <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (s_ready !== 1'b1 && n < 40);
    s_valid <= 1'b0;
    if (s_ready !== 1'b1) give_up("sample");
  endtask : push

  // Control fields change only with the link off
  task automatic cfg(input logic [7:0] ctrl, input logic [7:0] setup);
    wb(1'b1, A_SETUP, 8'h00);
    wb(1'b1, A_CTRL, ctrl);
    wb(1'b1, A_SETUP, setup);
    tick(1);
  endtask : cfg

  task automatic wait_words(input int cnt);
    int n;
    n = 0;
    while (model.got_q.size() < cnt && n < 200) begin
      tick(1);
      n++;
    end
    if (model.got_q.size() < cnt) give_up("lanes");
  endtask : wait_words

  task automatic t_reset();
    chk({pdown, mfcr, crun}, 3'b110, "disabled link");
    wb(1'b0, A_SOFT, 8'h00);
    chk(q, 32'h01, "soft sync reset");
    wb(1'b0, A_CTRL, 8'h00);
    chk(q, 32'h03, "link control reset");
    wb(1'b1, A_NONE, 8'hff);
    wb(1'b0, A_NONE, 8'h00);
    chk(q, 32'h0, "unmapped");
  endtask : t_reset

  task automatic t_sync();
    for (int s = 0; s < 3; s++) begin
      cfg({4'h0, s[1:0], 2'b11}, 8'h02);
      chk(ts_en, 1'b1, "ts receiver");
      wb(1'b1, A_SOFT, 8'h00);
      tick(1);
      chk(sync_req, 1'b1, "soft request");
      wb(1'b1, A_SOFT, 8'h01);
      tick(1);
      chk(sync_req, 1'b0, "soft release");
    end
    se_low <= 1'b1;
    cfg(8'h03, 8'h02);
    chk(sync_req, 1'b1, "pin request");
    wb(1'b0, A_STAT, 8'h00);
    chk(q[0], 1'b1, "status sync");
    cfg(8'h07, 8'h02);
    chk(sync_req, 1'b0, "pin not chosen");
    ts_low <= 1'b1;
    tick(1);
    chk(sync_req, 1'b1, "ts request");
    cfg(8'h0b, 8'h02);
    chk(sync_req, 1'b0, "software only");
    se_low <= 1'b0;
    ts_low <= 1'b0;
  endtask : t_sync

  task automatic t_stream();
    logic [7:0] ctl [5] = '{8'h02, 8'h12, 8'h00, 8'h03, 8'h02};
    logic [7:0] stp [5] = '{8'h11, 8'h31, 8'h11, 8'h11, 8'h15};
    logic [7:0] am;
    logic [8:0] e;
    int nd, nl, base;
    for (int i = 0; i < 5; i++) begin
      cfg(ctl[i], stp[i]);
      model.got_q.delete();
      model.lane_q.delete();
      nl = stp[i][6:4] + 1;
      base = 4 * ctl[i][4];
      am = ((8'h01 << nl) - 8'h01) << base;
      tick(1);
      chk({crun, pdown, mfcr}, 3'b100, "enabled link");
      chk(active, am, "lane map");
      for (int k = 0; k < 6; k++) push(9'h0a5 + k * 9'h13);
      wait_words(6);
      nd = 0;
      for (int k = 0; k < 6; k++) begin
        e = (9'h0a5 + k * 9'h13) ^ (ctl[i][1] ? 9'h000 : 9'h100);
        if (ctl[i][0] | stp[i][2]) nd += (model.got_q[k] !== e);
        else chk(model.got_q[k], e, "word");
        chk(model.lane_q[k], base + k % nl, "lane");
      end
      if (ctl[i][0] | stp[i][2]) begin
        chk(nd > 0, 1'b1, "scramble");
      end
    end
  endtask : t_stream

  task automatic t_fifo();
    cfg(8'h02, 8'h11);
    wb(1'b1, A_SOFT, 8'h00);
    model.got_q.delete();
    model.lane_q.delete();
    for (int k = 0; k < 16; k++) push(k[8:0] + 9'h040);
    tick(1);
    chk(s_ready, 1'b0, "fifo refuses");
    wb(1'b0, A_STAT, 8'h00);
    chk(q[2:0], 3'b101, "status full");
    stall <= 1'b1;
    wb(1'b1, A_SOFT, 8'h01);
    wait_words(16);
    for (int k = 0; k < 16; k++) chk(model.got_q[k], k + 9'h040, "order");
    wb(1'b0, A_STAT, 8'h00);
    chk(q[2:0], 3'b010, "status empty");
    stall <= 1'b0;
  endtask : t_fifo

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, cyc, stb, we, stall, se_low, ts_low, s_valid} = 8'h80;
    adr = 12'h000;
    wdat = 32'h0;
    s_data = 9'h000;
    err_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sync();
    t_stream();
    t_fifo();
    end_of_test();
  end
endmodule : link_sync_lane_control_tb_top
`default_nettype wire
